// >>> rtl/dbx_pkg.sv
// package of constants and types for the debug exception condition unit
package dbx_pkg;
    localparam int          DBX_NUM_BP      = 4;
    localparam logic [7:0]  DBX_VEC_DEBUG   = 8'h01;
    localparam logic [7:0]  DBX_VEC_BRKPT   = 8'h03;
    localparam logic [1:0]  DBX_COND_EXEC   = 2'h0;
    localparam logic [1:0]  DBX_COND_WRITE  = 2'h1;
    localparam logic [1:0]  DBX_COND_IO     = 2'h2;
    localparam logic [1:0]  DBX_COND_RDWR   = 2'h3;
    // status word layout
    localparam int          DBX_ST_HIT_LSB  = 0;
    localparam int          DBX_ST_BD_BIT   = 13;
    localparam int          DBX_ST_BS_BIT   = 14;
    localparam int          DBX_ST_BT_BIT   = 15;
    localparam int          DBX_ST_WIDTH    = 16;
    localparam logic [15:0] DBX_ST_RESET    = 16'h0000;
    typedef enum logic [1:0] {
        DBX_KIND_NONE,
        DBX_KIND_FAULT,
        DBX_KIND_TRAP
    } dbx_kind_t;
endpackage

// >>> rtl/dbx_bp_slot.sv
// one breakpoint slot: classifies a match by its condition field
`timescale 1ns/1ns
module dbx_bp_slot
    import dbx_pkg::*;
(
    input  wire logic       local_enable,
    input  wire logic       global_enable,
    input  wire logic [1:0] breakpoint_condition_field,
    input  wire logic       fetch_match,
    input  wire logic       data_rd_match,
    input  wire logic       data_wr_match,
    input  wire logic       io_match,
    output logic            inst_hit,
    output logic            data_hit
);
    logic en;
    // exact-match enables are not inputs at all: matching never depends on them
    assign en = local_enable | global_enable;
    always_comb begin
        inst_hit = 1'b0;
        data_hit = 1'b0;
        unique case (breakpoint_condition_field)
            DBX_COND_EXEC:  inst_hit = en & fetch_match;
            DBX_COND_WRITE: data_hit = en & data_wr_match;
            DBX_COND_IO:    data_hit = en & io_match;
            DBX_COND_RDWR:  data_hit = en & (data_rd_match | data_wr_match);
        endcase
    end
endmodule

// >>> rtl/dbx_step_ctl.sv
// single-step arming: skips the instruction that sets the trap flag
`timescale 1ns/1ns
module dbx_step_ctl (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic retire,
    input  wire logic trap_flag,
    input  wire logic task_switch,
    output logic      step_due
);
    logic armed_reg;
    logic boundary_reg;
    logic armed_now;
    // flag sampled one cycle after a boundary, once delivery or task load settled it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            boundary_reg <= 1'b0;
        end else begin
            boundary_reg <= retire | task_switch;
        end
    end
    // armed only when the flag was already set before this instruction began
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_reg <= 1'b0;
        end else if (boundary_reg) begin
            armed_reg <= trap_flag;
        end
    end
    assign armed_now = boundary_reg ? trap_flag : armed_reg;
    assign step_due  = retire & armed_now & trap_flag;
endmodule

// >>> rtl/dbx_core.sv
// debug exception condition detection, classification and status recording
`timescale 1ns/1ns
module dbx_core
    import dbx_pkg::*;
#(
    parameter int NUM_BP = DBX_NUM_BP
) (
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic [NUM_BP-1:0] local_enable,
    input  wire logic [NUM_BP-1:0] global_enable,
    input  wire logic [2*NUM_BP-1:0] breakpoint_condition_field,
    input  wire logic [NUM_BP-1:0] fetch_match,
    input  wire logic [NUM_BP-1:0] data_rd_match,
    input  wire logic [NUM_BP-1:0] data_wr_match,
    input  wire logic [NUM_BP-1:0] io_match,
    input  wire logic              decode_valid,
    input  wire logic              retire,
    input  wire logic              rep_string_move,
    input  wire logic              rep_port_string,
    input  wire logic              iter_done,
    input  wire logic              last_iter,
    input  wire logic              dbg_reg_move,
    input  wire logic              trap_flag_set,
    input  wire logic              trap_flag_clr,
    input  wire logic              soft_int_instr,
    input  wire logic              task_switch,
    input  wire logic              new_trap_flag,
    input  wire logic              new_task_trap_bit,
    input  wire logic              resume_flag_set,
    input  wire logic              guard_enable_set,
    input  wire logic              ext_int_pending,
    input  wire logic              status_clear,
    output logic                   exc_valid,
    output logic [7:0]             exc_vector,
    output dbx_kind_t              exc_kind,
    output logic                   fault_abort,
    output logic [DBX_ST_WIDTH-1:0] debug_status_reg,
    output logic                   trap_flag,
    output logic                   resume_flag,
    output logic                   register_guard_enable,
    output logic                   ext_int_take
);
    logic [NUM_BP-1:0] inst_hit;
    logic [NUM_BP-1:0] data_hit;
    logic              step_due;
    logic [NUM_BP-1:0] data_pend_reg;
    logic [NUM_BP-1:0] data_late_reg;
    logic              late_wait_reg;
    logic              task_trap_arm_reg;
    logic              task_trap_due;
    logic [NUM_BP-1:0] inst_fire;
    logic              guard_fire;
    logic              fault_now;
    logic [NUM_BP-1:0] data_report;
    logic              trap_now;
    logic              data_trap;
    logic              first_iter_reg;
    logic              ext_wait_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BP; gi++) begin : g_slot
            dbx_bp_slot u_slot (
                .local_enable               (local_enable[gi]),
                .global_enable              (global_enable[gi]),
                .breakpoint_condition_field (breakpoint_condition_field[2*gi +: 2]),
                .fetch_match                (fetch_match[gi]),
                .data_rd_match              (data_rd_match[gi]),
                .data_wr_match              (data_wr_match[gi]),
                .io_match                   (io_match[gi]),
                .inst_hit                   (inst_hit[gi]),
                .data_hit                   (data_hit[gi])
            );
        end
    endgenerate

    dbx_step_ctl u_step (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .retire      (retire),
        .trap_flag   (trap_flag),
        .task_switch (task_switch),
        .step_due    (step_due)
    );

    // faults are checked at decode, before the instruction runs
    assign inst_fire  = (decode_valid & ~resume_flag) ? inst_hit : '0;
    assign guard_fire = decode_valid & register_guard_enable & dbg_reg_move;
    assign fault_now  = (|inst_fire) | guard_fire;

    // data hits collect during the instruction and report at its retire
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_pend_reg <= '0;
        end else if (retire | iter_done) begin
            // hits handed on at an iteration boundary must not report twice
            data_pend_reg <= '0;
        end else begin
            data_pend_reg <= data_pend_reg | data_hit;
        end
    end

    // repeated move/store: hit seen in one iteration reports after the next
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_late_reg <= '0;
            late_wait_reg <= 1'b0;
        end else if (rep_string_move & iter_done & late_wait_reg) begin
            data_late_reg <= '0;
            late_wait_reg <= 1'b0;
        end else if (rep_string_move & iter_done & (|(data_pend_reg | data_hit))) begin
            data_late_reg <= data_pend_reg | data_hit;
            late_wait_reg <= 1'b1;
        end
    end

    // port string: first-iteration tracking for I/O hits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_iter_reg <= 1'b1;
        end else if (retire) begin
            first_iter_reg <= 1'b1;
        end else if (rep_port_string & iter_done) begin
            first_iter_reg <= 1'b0;
        end
    end

    always_comb begin
        data_report = '0;
        if (rep_string_move) begin
            if (iter_done & late_wait_reg) begin
                data_report = data_late_reg;
            end
        end else if (rep_port_string) begin
            // io and memory hits both land on the iteration that touches them
            if (iter_done) begin
                data_report = data_pend_reg | data_hit;
            end
        end else if (retire) begin
            data_report = data_pend_reg | data_hit;
        end
    end

    assign data_trap     = |data_report;
    assign task_trap_due = retire & task_trap_arm_reg;
    assign trap_now      = ~fault_now & (data_trap | step_due | task_trap_due);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            task_trap_arm_reg <= 1'b0;
        end else if (task_switch) begin
            task_trap_arm_reg <= new_task_trap_bit;
        end else if (retire) begin
            task_trap_arm_reg <= 1'b0;
        end
    end

    // exception delivery; instruction faults take precedence
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_valid   <= 1'b0;
            exc_vector  <= DBX_VEC_DEBUG;
            exc_kind    <= DBX_KIND_NONE;
            fault_abort <= 1'b0;
        end else begin
            exc_valid   <= fault_now | trap_now;
            exc_vector  <= DBX_VEC_DEBUG;
            fault_abort <= fault_now;
            if (fault_now) begin
                exc_kind <= DBX_KIND_FAULT;
            end else if (trap_now) begin
                exc_kind <= DBX_KIND_TRAP;
            end else begin
                exc_kind <= DBX_KIND_NONE;
            end
        end
    end

    // status flags written in the same edge as delivery, ahead of handler fetch
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            debug_status_reg <= DBX_ST_RESET;
        end else if (fault_now | trap_now) begin
            // hardware set wins over a coincident clear
            debug_status_reg[DBX_ST_HIT_LSB +: NUM_BP] <= (status_clear ? '0 :
                debug_status_reg[DBX_ST_HIT_LSB +: NUM_BP]) | inst_fire
                | (fault_now ? '0 : data_report);
            if (guard_fire) begin
                debug_status_reg[DBX_ST_BD_BIT] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[DBX_ST_BD_BIT] <= 1'b0;
            end
            if (trap_now & step_due) begin
                debug_status_reg[DBX_ST_BS_BIT] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[DBX_ST_BS_BIT] <= 1'b0;
            end
            if (trap_now & task_trap_due) begin
                debug_status_reg[DBX_ST_BT_BIT] <= 1'b1;
            end else if (status_clear) begin
                debug_status_reg[DBX_ST_BT_BIT] <= 1'b0;
            end
        end else if (status_clear) begin
            debug_status_reg <= DBX_ST_RESET;
        end
    end

    // trap flag: delivery clears it; privilege changes have no input here
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trap_flag <= 1'b0;
        end else if (fault_now | trap_now) begin
            trap_flag <= 1'b0;
        end else if (retire & soft_int_instr) begin
            trap_flag <= 1'b0;
        end else if (task_switch) begin
            trap_flag <= new_trap_flag;
        end else if (trap_flag_set) begin
            trap_flag <= 1'b1;
        end else if (trap_flag_clr) begin
            trap_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            resume_flag <= 1'b0;
        end else if (resume_flag_set) begin
            resume_flag <= 1'b1;
        end else if (retire) begin
            resume_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            register_guard_enable <= 1'b0;
        end else if (fault_now | trap_now) begin
            register_guard_enable <= 1'b0;
        end else if (guard_enable_set) begin
            register_guard_enable <= 1'b1;
        end
    end

    // interrupt waits one cycle behind the step trap, then is re-sampled
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_wait_reg <= 1'b0;
            ext_int_take <= 1'b0;
        end else begin
            ext_wait_reg <= trap_now & step_due & ext_int_pending;
            ext_int_take <= (ext_wait_reg & ext_int_pending)
                | (ext_int_pending & ~(trap_now | fault_now) & ~ext_wait_reg);
        end
    end

    property p_step_clears_tf;
        @(posedge sys_clk) disable iff (!arst_n)
        (trap_now & step_due) |=> (!trap_flag && debug_status_reg[DBX_ST_BS_BIT]);
    endproperty
    a_step_clears_tf: assert property (p_step_clears_tf) else $error("step trap wrong");

    property p_fault_kind;
        @(posedge sys_clk) disable iff (!arst_n)
        fault_now |=> (exc_valid && exc_kind == DBX_KIND_FAULT && fault_abort);
    endproperty
    a_fault_kind: assert property (p_fault_kind) else $error("fault not delivered");

    property p_rf_masks;
        @(posedge sys_clk) disable iff (!arst_n)
        (resume_flag && !guard_fire) |=> !fault_abort;
    endproperty
    a_rf_masks: assert property (p_rf_masks) else $error("resume flag ignored");

    property p_guard_bd;
        @(posedge sys_clk) disable iff (!arst_n)
        guard_fire |=> (debug_status_reg[DBX_ST_BD_BIT] && !register_guard_enable);
    endproperty
    a_guard_bd: assert property (p_guard_bd) else $error("guard fault wrong");

    property p_vector;
        @(posedge sys_clk) disable iff (!arst_n)
        exc_valid |-> exc_vector == DBX_VEC_DEBUG;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_task_bt;
        @(posedge sys_clk) disable iff (!arst_n)
        (trap_now & task_trap_due) |=> debug_status_reg[DBX_ST_BT_BIT];
    endproperty
    a_task_bt: assert property (p_task_bt) else $error("task flag missing");

    sequence s_step_int;
        trap_now & step_due & ext_int_pending;
    endsequence
    property p_int_after_step;
        @(posedge sys_clk) disable iff (!arst_n)
        s_step_int ##1 ext_int_pending |=> ext_int_take;
    endproperty
    a_int_after_step: assert property (p_int_after_step) else $error("int lost");

    property p_rf_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        (retire & !resume_flag_set) |=> !resume_flag;
    endproperty
    a_rf_clear: assert property (p_rf_clear) else $error("resume flag stuck");

    property p_port_io_first;
        @(posedge sys_clk) disable iff (!arst_n)
        (rep_port_string && !rep_string_move && iter_done && first_iter_reg
            && (|(data_hit & io_match)) && !fault_now) |=> (exc_valid && exc_kind == DBX_KIND_TRAP);
    endproperty
    a_port_io_first: assert property (p_port_io_first) else $error("io hit late");
endmodule

// >>> tb/testbench.sv
// self-checking bench for the debug exception condition unit
`timescale 1ns/1ns
module testbench;
    import dbx_pkg::*;
    typedef struct packed {
        logic [7:0]  en;
        logic [15:0] mt;
        logic [4:0]  op;
        logic [8:0]  ctl;
        dbx_kind_t   xk;
        logic [3:0]  xh;
        logic [2:0]  xs;
    } dbx_row_t;

    logic            sys_clk, arst_n;
    logic [3:0]      local_enable, global_enable, fetch_match;
    logic [3:0]      data_rd_match, data_wr_match, io_match;
    logic [7:0]      breakpoint_condition_field;
    logic            decode_valid, retire, rep_string_move, rep_port_string, iter_done;
    logic            last_iter, dbg_reg_move, trap_flag_set, trap_flag_clr, soft_int_instr;
    logic            task_switch, new_trap_flag, new_task_trap_bit, resume_flag_set;
    logic            guard_enable_set, ext_int_pending, status_clear;
    logic            exc_valid, fault_abort, trap_flag, resume_flag;
    logic            register_guard_enable, ext_int_take;
    logic [7:0]      exc_vector;
    dbx_kind_t       exc_kind;
    logic [15:0]     debug_status_reg;
    int              n_errors, n_compared, cycles, t_exc, t_int;

    // ordinary matches: bp0 exec, bp1 write, bp2 io, bp3 read/write
    dbx_row_t rows [8] = '{
        '{8'h01, 16'h0001, 5'h10, 9'h000, DBX_KIND_FAULT, 4'h1, 3'h0},
        '{8'h20, 16'h0200, 5'h08, 9'h000, DBX_KIND_TRAP,  4'h2, 3'h0},
        '{8'h04, 16'h4000, 5'h08, 9'h000, DBX_KIND_TRAP,  4'h4, 3'h0},
        '{8'h80, 16'h0080, 5'h08, 9'h000, DBX_KIND_TRAP,  4'h8, 3'h0},
        '{8'h00, 16'h0001, 5'h10, 9'h000, DBX_KIND_NONE,  4'h0, 3'h0},
        '{8'h02, 16'h0020, 5'h08, 9'h000, DBX_KIND_NONE,  4'h0, 3'h0},
        '{8'h08, 16'h0008, 5'h10, 9'h000, DBX_KIND_NONE,  4'h0, 3'h0},
        '{8'h08, 16'h0800, 5'h08, 9'h000, DBX_KIND_TRAP,  4'h8, 3'h0}
    };

    dbx_core #(.NUM_BP(4)) dbx_core_inst (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .local_enable(local_enable), .global_enable(global_enable),
        .breakpoint_condition_field(breakpoint_condition_field),
        .fetch_match(fetch_match), .data_rd_match(data_rd_match),
        .data_wr_match(data_wr_match), .io_match(io_match),
        .decode_valid(decode_valid), .retire(retire),
        .rep_string_move(rep_string_move), .rep_port_string(rep_port_string),
        .iter_done(iter_done), .last_iter(last_iter), .dbg_reg_move(dbg_reg_move),
        .trap_flag_set(trap_flag_set), .trap_flag_clr(trap_flag_clr),
        .soft_int_instr(soft_int_instr), .task_switch(task_switch),
        .new_trap_flag(new_trap_flag), .new_task_trap_bit(new_task_trap_bit),
        .resume_flag_set(resume_flag_set), .guard_enable_set(guard_enable_set),
        .ext_int_pending(ext_int_pending), .status_clear(status_clear),
        .exc_valid(exc_valid), .exc_vector(exc_vector), .exc_kind(exc_kind),
        .fault_abort(fault_abort), .debug_status_reg(debug_status_reg),
        .trap_flag(trap_flag), .resume_flag(resume_flag),
        .register_guard_enable(register_guard_enable), .ext_int_take(ext_int_take)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk1(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b got %b", nm, e, g);
        end
    endtask

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_k(input string nm, input dbx_kind_t e, input dbx_kind_t g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %0d got %0d", nm, e, g);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_rst();
        chk1("exc_valid", 1'b0, exc_valid);
        chk16("exc_vector", 16'h0001, {8'h00, exc_vector});
        chk_k("exc_kind", DBX_KIND_NONE, exc_kind);
        chk16("status", DBX_ST_RESET, debug_status_reg);
        chk1("trap_flag", 1'b0, trap_flag);
        chk1("resume_flag", 1'b0, resume_flag);
        chk1("guard", 1'b0, register_guard_enable);
        chk1("ext_int_take", 1'b0, ext_int_take);
        chk1("fault_abort", 1'b0, fault_abort);
    endtask

    // status is cleared first so each row sees only its own flags
    task automatic run(input dbx_row_t r);
        dbx_kind_t k;
        logic      ab;
        k = DBX_KIND_NONE;
        ab = 1'b0;
        t_exc = -1;
        t_int = -1;
        @(posedge sys_clk);
        status_clear <= 1'b1;
        @(posedge sys_clk);
        status_clear <= 1'b0;
        {global_enable, local_enable} <= r.en;
        {io_match, data_wr_match, data_rd_match, fetch_match} <= r.mt;
        {decode_valid, retire, rep_string_move, rep_port_string, iter_done} <= r.op;
        {guard_enable_set, resume_flag_set, new_task_trap_bit, new_trap_flag, task_switch,
         soft_int_instr, trap_flag_set, dbg_reg_move} <= r.ctl[7:0];
        if (r.ctl[8]) ext_int_pending <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {io_match, data_wr_match, data_rd_match, fetch_match} <= 16'h0000;
            {decode_valid, retire, rep_string_move, rep_port_string, iter_done} <= 5'h00;
            {guard_enable_set, resume_flag_set, new_task_trap_bit, new_trap_flag, task_switch,
             soft_int_instr, trap_flag_set, dbg_reg_move} <= 8'h00;
            #1;
            if (exc_valid === 1'b1 && t_exc < 0) begin
                t_exc = i;
                k = exc_kind;
            end
            if (fault_abort === 1'b1) ab = 1'b1;
            if (ext_int_take === 1'b1 && t_int < 0) t_int = i;
        end
        chk1("exc_valid", r.xk != DBX_KIND_NONE, t_exc >= 0);
        chk_k("exc_kind", r.xk, k);
        chk1("fault_abort", r.xk == DBX_KIND_FAULT, ab);
        chk16("exc_vector", 16'h0001, {8'h00, exc_vector});
        chk16("status", {r.xs, 9'h000, r.xh}, debug_status_reg);
    endtask

    // the whole run needs about 160 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        arst_n = 1'b0;
        {local_enable, global_enable, fetch_match, data_rd_match} = 16'h0000;
        {data_wr_match, io_match} = 8'h00;
        breakpoint_condition_field = {DBX_COND_RDWR, DBX_COND_IO, DBX_COND_WRITE, DBX_COND_EXEC};
        {decode_valid, retire, rep_string_move, rep_port_string, iter_done} = 5'h00;
        {last_iter, dbg_reg_move, trap_flag_set, trap_flag_clr, soft_int_instr} = 5'h00;
        {task_switch, new_trap_flag, new_task_trap_bit, resume_flag_set} = 4'h0;
        {guard_enable_set, ext_int_pending, status_clear} = 3'h0;
        n_errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk_rst();
        @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
        end
        run('{8'h03, 16'h0201, 5'h18, 9'h000, DBX_KIND_FAULT, 4'h1, 3'h0});
        run('{8'h03, 16'h0000, 5'h00, 9'h040, DBX_KIND_NONE, 4'h0, 3'h0});
        chk1("resume_flag", 1'b1, resume_flag);
        run('{8'h03, 16'h0001, 5'h10, 9'h000, DBX_KIND_NONE, 4'h0, 3'h0});
        run('{8'h03, 16'h0200, 5'h08, 9'h000, DBX_KIND_TRAP, 4'h2, 3'h0});
        chk1("resume_flag", 1'b0, resume_flag);
        run('{8'h00, 16'h0000, 5'h00, 9'h080, DBX_KIND_NONE, 4'h0, 3'h0});
        chk1("guard", 1'b1, register_guard_enable);
        run('{8'h00, 16'h0000, 5'h10, 9'h001, DBX_KIND_FAULT, 4'h0, 3'h1});
        chk1("guard", 1'b0, register_guard_enable);
        run('{8'h00, 16'h0000, 5'h00, 9'h002, DBX_KIND_NONE, 4'h0, 3'h0});
        chk1("trap_flag", 1'b1, trap_flag);
        run('{8'h00, 16'h0000, 5'h08, 9'h000, DBX_KIND_NONE, 4'h0, 3'h0});
        run('{8'h00, 16'h0000, 5'h08, 9'h100, DBX_KIND_TRAP, 4'h0, 3'h2});
        chk1("trap_flag", 1'b0, trap_flag);
        chk1("ext_int_order", 1'b1, t_exc >= 0 && t_int > t_exc);
        ext_int_pending <= 1'b0;
        run('{8'h00, 16'h0000, 5'h00, 9'h002, DBX_KIND_NONE, 4'h0, 3'h0});
        run('{8'h00, 16'h0000, 5'h08, 9'h004, DBX_KIND_NONE, 4'h0, 3'h0});
        chk1("trap_flag", 1'b0, trap_flag);
        run('{8'h00, 16'h0000, 5'h00, 9'h038, DBX_KIND_NONE, 4'h0, 3'h0});
        chk1("trap_flag", 1'b1, trap_flag);
        run('{8'h00, 16'h0000, 5'h08, 9'h000, DBX_KIND_TRAP, 4'h0, 3'h6});
        run('{8'h02, 16'h0200, 5'h05, 9'h000, DBX_KIND_NONE, 4'h0, 3'h0});
        run('{8'h02, 16'h0000, 5'h05, 9'h000, DBX_KIND_TRAP, 4'h2, 3'h0});
        run('{8'h04, 16'h4000, 5'h03, 9'h000, DBX_KIND_TRAP, 4'h4, 3'h0});
        run('{8'h02, 16'h0200, 5'h03, 9'h000, DBX_KIND_TRAP, 4'h2, 3'h0});
        // software write path of the trap flag: set, then clear
        @(posedge sys_clk);
        trap_flag_set <= 1'b1;
        @(posedge sys_clk);
        trap_flag_set <= 1'b0;
        trap_flag_clr <= 1'b1;
        #1;
        chk1("trap_flag", 1'b1, trap_flag);
        @(posedge sys_clk);
        trap_flag_clr <= 1'b0;
        #1;
        chk1("trap_flag", 1'b0, trap_flag);
        // mid-run reset while hit flags are still standing
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_rst();
        test_done();
    end
endmodule
